// *** hdl/tppl_pkg.sv ***
/*
 * Constants shared by the touch-probe position latch: object indices,
 * bit positions of the control and status words and reset values.
 * Assumes nothing of its surroundings; it holds definitions only.
 */
package tppl_pkg;

   // ----------------------------------------------------------------------
   // Object indices
   // ----------------------------------------------------------------------
   localparam logic [15:0] IDX_PROBE_CONTROL = 16'h60b8;
   localparam logic [15:0] IDX_PROBE_STATE   = 16'h60b9;
   localparam logic [15:0] IDX_PROBE_ONE_POS = 16'h60ba;
   localparam logic [15:0] IDX_PROBE_TWO_POS = 16'h60bc;

   // ----------------------------------------------------------------------
   // Control word: per-channel bit positions, channel two is offset by 8
   // ----------------------------------------------------------------------
   localparam int CH_STRIDE    = 8;
   localparam int CTL_ENABLE   = 0;
   localparam int CTL_CONT     = 1;
   localparam int CTL_SOURCE   = 2;
   localparam int CTL_SAMPLE   = 4;
   localparam logic [15:0] CTL_WRITE_MASK = 16'h1717;
   localparam logic [15:0] CTL_RESET      = 16'h0000;

   // ----------------------------------------------------------------------
   // Status word: per-channel bit positions
   // ----------------------------------------------------------------------
   localparam int STS_ENABLED  = 0;
   localparam int STS_STORED   = 1;
   localparam int STS_TOGGLE   = 7;

   localparam int          NUM_CH    = 2;
   localparam logic [31:0] POS_RESET = 32'h0000_0000;

   // Input pins that go through the synchroniser: probe one, probe two, zero marker.
   localparam int NUM_PINS  = 3;
   localparam int PIN_ONE   = 0;
   localparam int PIN_TWO   = 1;
   localparam int PIN_ZERO  = 2;

endpackage

// *** hdl/tppl_sync_edge.sv ***
/*
 * Two-stage synchroniser with rising-edge detector for one input pin.
 * Assumes the pin is asynchronous to clock; the edge pulse lasts one cycle.
 */
`timescale 1ns/1ns
module tppl_sync_edge (
   // Clock and reset
   input  wire logic clock,
   input  wire logic arst_n,
   // Pin and result
   input  wire logic pinIn,
   output logic      riseEdge
);

   logic meta_reg;
   logic sync_reg;
   logic prev_reg;
   logic meta_next;
   logic sync_next;
   logic prev_next;

   always_comb begin
      meta_next = pinIn;
      sync_next = meta_reg;
      prev_next = sync_reg;
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         prev_reg <= 1'b0;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
         prev_reg <= prev_next;
      end
   end

   // Only the second stage and its delayed copy feed the detector.
   assign riseEdge = sync_reg & ~prev_reg;

endmodule

// *** hdl/tppl_top.sv ***
/*
 * Two-channel touch-probe position latch. The network side reads and
 * writes the objects through a simple indexed access port; the control
 * and status words and both latched positions are also driven out for
 * cyclic mapping.
 * Assumes position and homingActive come from logic on the same clock, and
 * that the probe pins and the encoder zero marker are asynchronous.
 */
// How it works
// R01: Channel one works only while control bit 0 is set.
// R02: Mode bits 1 and 9: 0 latches the first trigger, 1 every trigger.
// R03: Control bit 2 picks probe one input (0) or encoder zero marker (1).
// R04: Sampling bits 4 and 12 start sampling when set, stop when cleared.
// R05: Channel two works only while control bit 8 is set.
// R06: Bit 10 at 0 triggers channel two on its pin; 1 is reserved.
// R07: Control word resets to zero: both channels off and idle.
// R08: Homing start clears channel one enable; it stays unusable throughout homing.
// R09: Continuous mode re-reads bit 2 at every latch start.
// R10: Status bits 0 and 8 show each channel's enable.
// R11: Status bits 1 and 9 show a latched position is held.
// R12: In continuous mode status bit 7 or 15 toggles on every latch.
// R13: Channel one trigger captures position into a read-only signed register.
// R14: Channel two trigger captures position into its own read-only register.
// R15: Single mode ignores triggers after the first until sampling restarts.
`timescale 1ns/1ns
module tppl_top
   import tppl_pkg::*;
(
   // Clock and reset
   input  wire logic               clock,
   input  wire logic               arst_n,
   // Object access port
   input  wire logic               objWrite,
   input  wire logic               objRead,
   input  wire logic [15:0]        objIndex,
   input  wire logic [15:0]        objWriteData,
   output logic      [31:0]        objReadData,
   output logic                    objReadValid,
   output logic                    objError,
   // Drive state
   input  wire logic signed [31:0] position,
   input  wire logic               homingActive,
   // Pins
   input  wire logic               probeOneInput,
   input  wire logic               probeTwoInput,
   input  wire logic               encoderZeroPulse,
   // Cyclic images
   output logic      [15:0]        probeControl,
   output logic      [15:0]        probeState,
   output logic signed [31:0]      probeOneLatchedPosition,
   output logic signed [31:0]      probeTwoLatchedPosition
);

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   logic [NUM_PINS-1:0] pinRaw;
   logic [NUM_PINS-1:0] pinEdge;

   assign pinRaw[PIN_ONE]  = probeOneInput;
   assign pinRaw[PIN_TWO]  = probeTwoInput;
   assign pinRaw[PIN_ZERO] = encoderZeroPulse;

   for (genvar p = 0; p < NUM_PINS; p++) begin : gPin
      tppl_sync_edge uSync (
         .clock    (clock),
         .arst_n   (arst_n),
         .pinIn    (pinRaw[p]),
         .riseEdge (pinEdge[p])
      );
   end

   // ----------------------------------------------------------------------
   // Control word and homing
   // ----------------------------------------------------------------------
   logic [15:0] control_reg;
   logic [15:0] control_next;
   logic        homingPrev_reg;
   logic        homingPrev_next;
   logic        homingStart;

   assign homingStart = homingActive & ~homingPrev_reg;

   always_comb begin
      control_next    = control_reg;
      homingPrev_next = homingActive;
      if (objWrite && objIndex == IDX_PROBE_CONTROL) begin
         control_next = objWriteData & CTL_WRITE_MASK;
      end
      // Homing wins over a write in the same cycle so the channel cannot sneak back on.
      if (homingStart) begin
         control_next[CTL_ENABLE] = 1'b0;                                        // [R08]
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         control_reg    <= CTL_RESET;                                            // [R07]
         homingPrev_reg <= 1'b0;
      end else begin
         control_reg    <= control_next;
         homingPrev_reg <= homingPrev_next;
      end
   end

   // ----------------------------------------------------------------------
   // Channel latches
   // ----------------------------------------------------------------------
   logic [NUM_CH-1:0]        armed_reg;
   logic [NUM_CH-1:0]        armed_next;
   logic [NUM_CH-1:0]        stored_reg;
   logic [NUM_CH-1:0]        stored_next;
   logic [NUM_CH-1:0]        toggle_reg;
   logic [NUM_CH-1:0]        toggle_next;
   logic [NUM_CH-1:0]        active_reg;
   logic [NUM_CH-1:0]        active_next;
   logic                     zeroSel_reg;
   logic                     zeroSel_next;
   logic signed [31:0]       pos_reg  [NUM_CH];
   logic signed [31:0]       pos_next [NUM_CH];
   logic [NUM_CH-1:0]        chEnable;
   logic [NUM_CH-1:0]        chTrigger;

   // Channel one is held off for the whole homing run, not only at its start.
   assign chEnable[0] = control_reg[CTL_ENABLE] & ~homingActive;                 // [R01] [R08]
   assign chEnable[1] = control_reg[CH_STRIDE + CTL_ENABLE];                     // [R05]

   // The reserved source value for channel two yields no trigger at all.
   assign chTrigger[0] = zeroSel_reg ? pinEdge[PIN_ZERO] : pinEdge[PIN_ONE];    // [R03]
   assign chTrigger[1] = ~control_reg[CH_STRIDE + CTL_SOURCE] & pinEdge[PIN_TWO]; // [R06]

   always_comb begin
      armed_next   = armed_reg;
      stored_next  = stored_reg;
      toggle_next  = toggle_reg;
      zeroSel_next = zeroSel_reg;
      for (int c = 0; c < NUM_CH; c++) begin
         pos_next[c]    = pos_reg[c];
         active_next[c] = chEnable[c] & control_reg[c*CH_STRIDE + CTL_SAMPLE];   // [R04]
         if (!chEnable[c]) begin
            stored_next[c] = 1'b0;
         end
         if (!active_next[c]) begin
            armed_next[c] = 1'b0;                                                // [R04]
         end else if (!active_reg[c]) begin
            // Latch start: arm, drop any old capture, read the source choice.
            armed_next[c]  = 1'b1;                                               // [R15]
            stored_next[c] = 1'b0;
            if (c == 0) begin
               zeroSel_next = control_reg[CTL_SOURCE];                           // [R09]
            end
         end else if (armed_reg[c] && chTrigger[c]) begin
            pos_next[c]    = position;                                           // [R13] [R14]
            stored_next[c] = 1'b1;                                               // [R11]
            if (control_reg[c*CH_STRIDE + CTL_CONT]) begin
               toggle_next[c] = ~toggle_reg[c];                                  // [R12]
               if (c == 0) begin
                  zeroSel_next = control_reg[CTL_SOURCE];                        // [R09]
               end
            end else begin
               armed_next[c] = 1'b0;                                             // [R02] [R15]
            end
         end
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         armed_reg   <= '0;
         stored_reg  <= '0;
         toggle_reg  <= '0;
         active_reg  <= '0;
         zeroSel_reg <= 1'b0;
         for (int c = 0; c < NUM_CH; c++) begin
            pos_reg[c] <= POS_RESET;
         end
      end else begin
         armed_reg   <= armed_next;
         stored_reg  <= stored_next;
         toggle_reg  <= toggle_next;
         active_reg  <= active_next;
         zeroSel_reg <= zeroSel_next;
         for (int c = 0; c < NUM_CH; c++) begin
            pos_reg[c] <= pos_next[c];
         end
      end
   end

   // ----------------------------------------------------------------------
   // Status word
   // ----------------------------------------------------------------------
   logic [15:0] state_reg;
   logic [15:0] state_next;

   always_comb begin
      state_next = 16'h0000;
      for (int c = 0; c < NUM_CH; c++) begin
         state_next[c*CH_STRIDE + STS_ENABLED] = chEnable[c];                    // [R10]
         state_next[c*CH_STRIDE + STS_STORED]  = stored_reg[c];                  // [R11]
         state_next[c*CH_STRIDE + STS_TOGGLE]  = toggle_reg[c];                  // [R12]
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= 16'h0000;
      end else begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------------------------------------
   // Object access answers
   // ----------------------------------------------------------------------
   logic [31:0] rdData_reg;
   logic [31:0] rdData_next;
   logic        rdValid_reg;
   logic        rdValid_next;
   logic        error_reg;
   logic        error_next;

   always_comb begin
      rdData_next  = rdData_reg;
      rdValid_next = 1'b0;
      error_next   = 1'b0;
      if (objRead) begin
         rdValid_next = 1'b1;
         case (objIndex)
            IDX_PROBE_CONTROL: rdData_next = {16'h0000, control_reg};
            IDX_PROBE_STATE:   rdData_next = {16'h0000, state_reg};
            IDX_PROBE_ONE_POS: rdData_next = pos_reg[0];
            IDX_PROBE_TWO_POS: rdData_next = pos_reg[1];
            default: begin
               rdData_next = 32'h0000_0000;
               error_next  = 1'b1;
            end
         endcase
      end else if (objWrite && objIndex != IDX_PROBE_CONTROL) begin
         // Status and positions are read-only; writes to them are refused.
         error_next = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rdData_reg  <= 32'h0000_0000;
         rdValid_reg <= 1'b0;
         error_reg   <= 1'b0;
      end else begin
         rdData_reg  <= rdData_next;
         rdValid_reg <= rdValid_next;
         error_reg   <= error_next;
      end
   end

   assign objReadData             = rdData_reg;
   assign objReadValid            = rdValid_reg;
   assign objError                = error_reg;
   assign probeControl            = control_reg;
   assign probeState              = state_reg;
   assign probeOneLatchedPosition = pos_reg[0];
   assign probeTwoLatchedPosition = pos_reg[1];

endmodule

// *** tb/tppl_top_monitor.sv ***
/*
 * Port checker for the touch-probe position latch, bound to tppl_top.
 * Makes no assumption about homing during control writes; the checks that need homing low test for it themselves.
 */
`timescale 1ns/1ns
module tppl_top_monitor
   import tppl_pkg::*;
(
   // Clock and reset
   input wire logic               clock,
   input wire logic               arst_n,
   // Object access port
   input wire logic               objWrite,
   input wire logic               objRead,
   input wire logic [15:0]        objIndex,
   input wire logic [15:0]        objWriteData,
   input wire logic [31:0]        objReadData,
   input wire logic               objReadValid,
   input wire logic               objError,
   // Drive state and images
   input wire logic               homingActive,
   input wire logic [15:0]        probeControl,
   input wire logic [15:0]        probeState,
   input wire logic signed [31:0] probeOneLatchedPosition,
   input wire logic signed [31:0] probeTwoLatchedPosition
);
   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);
   a_ctl_write_applied: assert property (
      objWrite && !objRead && objIndex == IDX_PROBE_CONTROL && !homingActive
      |=> probeControl == ($past(objWriteData) & CTL_WRITE_MASK)) else $error("control write not applied");
   a_enable_shown: assert property (
      $rose(probeControl[0]) && !homingActive |-> ##2 probeState[0]) else $error("enable not shown");
   a_homing_disables: assert property (
      $rose(homingActive) |-> ##[1:2] !probeControl[0]) else $error("homing kept channel one");
   a_pos_read_back: assert property (
      objRead && objIndex == IDX_PROBE_ONE_POS
      |=> objReadValid && objReadData == $past(probeOneLatchedPosition)) else $error("position read wrong");
   a_ro_write_refused: assert property (
      objWrite && !objRead && objIndex != IDX_PROBE_CONTROL |=> objError) else $error("write not refused");
   a_one_latch_gated: assert property (
      $changed(probeOneLatchedPosition) |-> probeControl[0] && probeControl[4]) else $error("idle ch1 latched");
   a_stored_flag_set: assert property (
      $changed(probeOneLatchedPosition) |=> probeState[1]) else $error("stored flag missing");
   a_toggle_cont_only: assert property (
      $changed(probeState[7]) |-> probeControl[1]) else $error("toggle outside continuous mode");
   a_two_latch_gated: assert property (
      $changed(probeTwoLatchedPosition) |-> probeControl[8] && probeControl[12] && !probeControl[10])
      else $error("idle ch2 latched");
   c_one_latch: cover property ($changed(probeOneLatchedPosition));
   c_two_toggle: cover property ($changed(probeState[15]));
   c_homing: cover property ($rose(homingActive));
endmodule
bind tppl_top tppl_top_monitor i_tppl_top_monitor (.clock(clock), .arst_n(arst_n), .objWrite(objWrite),
   .objRead(objRead), .objIndex(objIndex), .objWriteData(objWriteData), .objReadData(objReadData),
   .objReadValid(objReadValid), .objError(objError), .homingActive(homingActive),
   .probeControl(probeControl), .probeState(probeState),
   .probeOneLatchedPosition(probeOneLatchedPosition), .probeTwoLatchedPosition(probeTwoLatchedPosition));

// *** tb/tppl_probe_model.sv ***
/*
 * Far-side model: the probe pins and the encoder zero marker.
 * Assumes the bench calls fire only from one process at a time.
 */
`timescale 1ns/1ns
module tppl_probe_model (
   // Clock
   input wire logic clock,
   // Pins
   output logic     probeOneInput,
   output logic     probeTwoInput,
   output logic     encoderZeroPulse
);
   // ----------------------------------------------------------------------
   // Pulse generator
   // ----------------------------------------------------------------------
   initial {probeOneInput, probeTwoInput, encoderZeroPulse} = 3'h0;
   // Four cycles high, twice what the synchroniser needs, then a settle gap.
   task automatic fire(input int pin);
      @(posedge clock);
      #1;
      case (pin)
         0: probeOneInput = 1'b1;
         1: probeTwoInput = 1'b1;
         default: encoderZeroPulse = 1'b1;
      endcase
      repeat (4) @(posedge clock);
      #1;
      {probeOneInput, probeTwoInput, encoderZeroPulse} = 3'h0;
      repeat (8) @(posedge clock);
   endtask
endmodule

// *** tb/test_tppl_top.sv ***
/*
 * Self-checking bench for tppl_top: object reads and writes plus probe pulses.
 * Assumes the probe model and the bound checker sit beside the design.
 */
`timescale 1ns/1ns
module test_tppl_top;
   import tppl_pkg::*;
   logic               clock, arst_n, objWrite, objRead, homingActive, objReadValid, objError;
   logic               rdErr, rdValid, probeOneInput, probeTwoInput, encoderZeroPulse;
   logic [15:0]        objIndex, objWriteData, probeControl, probeState;
   logic [31:0]        objReadData, rdData;
   logic signed [31:0] position, probeOneLatchedPosition, probeTwoLatchedPosition;
   int                 errorCnt, compares, cycles;
   localparam logic [15:0] C = IDX_PROBE_CONTROL;

   tppl_top i_tppl_top (.clock(clock), .arst_n(arst_n), .objWrite(objWrite), .objRead(objRead),
      .objIndex(objIndex), .objWriteData(objWriteData), .objReadData(objReadData),
      .objReadValid(objReadValid), .objError(objError), .position(position), .homingActive(homingActive),
      .probeOneInput(probeOneInput), .probeTwoInput(probeTwoInput), .encoderZeroPulse(encoderZeroPulse),
      .probeControl(probeControl), .probeState(probeState),
      .probeOneLatchedPosition(probeOneLatchedPosition), .probeTwoLatchedPosition(probeTwoLatchedPosition));
   tppl_probe_model i_tppl_probe_model (.clock(clock), .probeOneInput(probeOneInput),
      .probeTwoInput(probeTwoInput), .encoderZeroPulse(encoderZeroPulse));

   // ----------------------------------------------------------------------
   // Clock, timeout and tasks
   // ----------------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         errorCnt++;
         finalReport();
      end
   end
   task automatic finalReport();
      if (errorCnt == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         errorCnt++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   // Waits after the pulse so the enable reaches status and the channel arms.
   task automatic wr(input logic [15:0] idx, input logic [15:0] data);
      @(posedge clock);
      #1 {objWrite, objIndex, objWriteData} = {1'b1, idx, data};
      @(posedge clock);
      #1 objWrite = 1'b0;
      rdErr = objError;
      repeat (3) @(posedge clock);
      #1;
   endtask
   task automatic rd(input logic [15:0] idx);
      @(posedge clock);
      #1 {objRead, objIndex} = {1'b1, idx};
      @(posedge clock);
      #1 objRead = 1'b0;
      {rdData, rdErr, rdValid} = {objReadData, objError, objReadValid};
   endtask
   task automatic chk(input logic [15:0] idx, input logic [31:0] exp);
      rd(idx);
      cmp($sformatf("index %h", idx), exp, rdData);
      cmp("objReadValid", 32'h1, {31'h0, rdValid});
   endtask
   task automatic probe(input int pin, input logic [31:0] pos);
      position = pos;
      i_tppl_probe_model.fire(pin);
   endtask

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial begin
      {arst_n, objWrite, objRead, homingActive} = 4'h0;
      {objIndex, objWriteData, position} = 64'h0;
      {cycles, errorCnt, compares} = '0;
      repeat (12) @(posedge clock);
      #1 arst_n = 1'b1;
      chk(C, 32'h0);
      chk(IDX_PROBE_STATE, 32'h0);
      wr(C, 16'h00f1);
      chk(C, 32'h0011);
      probe(0, 32'h1234);
      probe(0, 32'h5678);
      chk(IDX_PROBE_ONE_POS, 32'h1234);
      chk(IDX_PROBE_STATE, 32'h0003);
      wr(C, 16'h0001);
      probe(0, 32'h9999);
      chk(IDX_PROBE_ONE_POS, 32'h1234);
      wr(C, 16'h0011);
      probe(0, 32'h5678);
      chk(IDX_PROBE_ONE_POS, 32'h5678);
      wr(C, 16'h0001);
      wr(C, 16'h0017);
      probe(0, 32'h1111);
      chk(IDX_PROBE_ONE_POS, 32'h5678);
      probe(2, 32'h2222);
      chk(IDX_PROBE_ONE_POS, 32'h2222);
      chk(IDX_PROBE_STATE, 32'h0083);
      wr(C, 16'h0013);
      probe(0, 32'h3333);
      chk(IDX_PROBE_ONE_POS, 32'h2222);
      probe(2, 32'h4444);
      chk(IDX_PROBE_STATE, 32'h0003);
      probe(0, 32'h5555);
      chk(IDX_PROBE_ONE_POS, 32'h5555);
      wr(C, 16'h1300);
      probe(1, 32'hffff_fff0);
      chk(IDX_PROBE_TWO_POS, 32'hffff_fff0);
      rd(IDX_PROBE_STATE);
      cmp("probeState", 32'h8300, rdData & 32'hff00);
      wr(C, 16'h1f00);
      chk(C, 32'h1700);
      probe(1, 32'h7777);
      chk(IDX_PROBE_TWO_POS, 32'hffff_fff0);
      wr(IDX_PROBE_STATE, 16'h0001);
      cmp("objError", 32'h1, {31'h0, rdErr});
      rd(16'h1234);
      cmp("unknown data", 32'h0, rdData);
      cmp("unknown error", 32'h1, {31'h0, rdErr});
      wr(C, 16'h0011);
      homingActive = 1'b1;
      chk(C, 32'h0010);
      wr(C, 16'h0011);
      chk(IDX_PROBE_STATE, 32'h8080);
      probe(0, 32'h8888);
      chk(IDX_PROBE_ONE_POS, 32'h5555);
      homingActive = 1'b0;
      finalReport();
   end
endmodule
